// ---- include/dmas_defs.svh ----
`ifndef DMAS_DEFS_SVH
`define DMAS_DEFS_SVH

// Datapath widths.
`define DMAS_A_W 27
`define DMAS_B_W 18
`define DMAS_PROD_W 45
`define DMAS_P_W 48
`define DMAS_X_W 96
`define DMAS_SEG_W 12
`define DMAS_NSEG 8
`define DMAS_NLANE 4

// Reset value and counter step.
`define DMAS_P_RST 48'h0000_0000_0000
`define DMAS_ONE 48'h0000_0000_0001

// Lane modes.
`define DMAS_LANE_ONE 2'h0
`define DMAS_LANE_DUAL 2'h1
`define DMAS_LANE_QUAD 2'h2

// Result selection.
`define DMAS_FN_ARITH 2'h0
`define DMAS_FN_LOGIC 2'h1
`define DMAS_FN_COUNT 2'h3

// Logic unit functions.
`define DMAS_LG_XOR 4'h0
`define DMAS_LG_XNOR 4'h1
`define DMAS_LG_AND 4'h2
`define DMAS_LG_ANDN 4'h3
`define DMAS_LG_NAND 4'h4
`define DMAS_LG_OR 4'h5
`define DMAS_LG_ORN 4'h6
`define DMAS_LG_NOR 4'h7
`define DMAS_LG_NAND_X 4'h8
`define DMAS_LG_NOR_X 4'h9

// Parity segment widths.
`define DMAS_XW_12 2'h0
`define DMAS_XW_24 2'h1
`define DMAS_XW_48 2'h2
`define DMAS_XW_96 2'h3

`endif

// ---- include/dmas_pkg.sv ----
`include "dmas_defs.svh"

package dmas_pkg;

    typedef enum logic [1:0] {
        LANE_ONE = `DMAS_LANE_ONE,
        LANE_DUAL = `DMAS_LANE_DUAL,
        LANE_QUAD = `DMAS_LANE_QUAD
    } dmas_lane_type;

    typedef enum logic [1:0] {
        FN_ARITH = `DMAS_FN_ARITH,
        FN_LOGIC = `DMAS_FN_LOGIC,
        FN_COUNT = `DMAS_FN_COUNT
    } dmas_fn_type;

    typedef struct packed {
        logic bypass;
        logic pre_en;
        logic pre_sub;
        logic acc;
        logic sub;
        logic cascade;
        dmas_lane_type lane;
        dmas_fn_type fn;
        logic [3:0] logic_sel;
        logic cnt_up;
        logic cnt_en;
        logic rnd_en;
        logic [1:0] xor_w;
    } dmas_ctrl_type;

    typedef struct packed {
        dmas_ctrl_type ctrl;
        logic [`DMAS_A_W-1:0] a;
        logic [`DMAS_A_W-1:0] d;
        logic [`DMAS_B_W-1:0] b;
        logic [`DMAS_P_W-1:0] opa;
        logic [`DMAS_P_W-1:0] opc;
    } dmas_in_type;

    typedef struct packed {
        dmas_ctrl_type ctrl;
        logic [`DMAS_PROD_W-1:0] prod;
        logic [`DMAS_P_W-1:0] opa;
        logic [`DMAS_P_W-1:0] opc;
    } dmas_mul_type;

endpackage

// ---- rtl/dmas_xor.sv ----
`include "dmas_defs.svh"

module dmas_xor
    import dmas_pkg::*;
(
    // Operand and width select.
    input wire logic [`DMAS_X_W-1:0] data,
    input wire logic [1:0] width,
    // One parity bit per segment, low bits first.
    output logic [`DMAS_NSEG-1:0] parity
);

    logic [`DMAS_NSEG-1:0] seg;

    always_comb begin
        for (int k = 0; k < `DMAS_NSEG; k++) begin
            seg[k] = ^data[k*`DMAS_SEG_W +: `DMAS_SEG_W];
        end
        parity = '0;
        unique case (width)
            `DMAS_XW_12: begin
                parity = seg;
            end
            `DMAS_XW_24: begin
                for (int k = 0; k < `DMAS_NSEG / 2; k++) begin
                    parity[k] = ^seg[2*k +: 2];
                end
            end
            `DMAS_XW_48: begin
                for (int k = 0; k < `DMAS_NSEG / 4; k++) begin
                    parity[k] = ^seg[4*k +: 4];
                end
            end
            `DMAS_XW_96: begin
                parity[0] = ^seg;
            end
        endcase
    end

endmodule

// ---- rtl/dmas_slice.sv ----
`include "dmas_defs.svh"

module dmas_slice
    import dmas_pkg::*;
#(
    parameter bit IN_REG = 1'b1,
    parameter bit MUL_REG = 1'b1
)
(
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic RST,
    // Multiplier and pre-adder operands.
    input wire logic [`DMAS_A_W-1:0] MUL_A,
    input wire logic [`DMAS_A_W-1:0] PRE_D,
    input wire logic [`DMAS_B_W-1:0] MUL_B,
    // Wide operands.
    input wire logic [`DMAS_P_W-1:0] OPA,
    input wire logic [`DMAS_P_W-1:0] OPC,
    // Operation select.
    input wire dmas_ctrl_type CTRL,
    // Pattern detector setup.
    input wire logic [`DMAS_P_W-1:0] PATTERN,
    input wire logic [`DMAS_P_W-1:0] MASK,
    // Cascade from the neighbouring slice.
    input wire logic [`DMAS_P_W-1:0] CASC_IN,
    input wire logic CASC_MATCH_IN,
    // Results.
    output logic [`DMAS_P_W-1:0] RESULT,
    output logic [`DMAS_P_W-1:0] CASC_OUT,
    output logic PAT_MATCH,
    output logic PAT_WIDE,
    output logic [`DMAS_NSEG-1:0] XOR_PAR
);

    function automatic logic [`DMAS_P_W-1:0] lane_add(
        input logic [`DMAS_P_W-1:0] z,
        input logic [`DMAS_P_W-1:0] x,
        input logic sub,
        input dmas_lane_type mode
    );
        logic [`DMAS_P_W-1:0] xx;
        logic [`DMAS_P_W-1:0] r;
        logic [`DMAS_SEG_W:0] s;
        logic c;
        xx = sub ? ~x : x;
        c = sub;
        r = '0;
        for (int q = 0; q < `DMAS_NLANE; q++) begin
            // Carry is cut at each lane edge.
            if ((mode == LANE_QUAD && q != 0) || (mode == LANE_DUAL && q == `DMAS_NLANE / 2)) begin
                c = sub;
            end
            s = {1'b0, z[q*`DMAS_SEG_W +: `DMAS_SEG_W]} + {1'b0, xx[q*`DMAS_SEG_W +: `DMAS_SEG_W]}
                + (`DMAS_SEG_W+1)'(c);
            r[q*`DMAS_SEG_W +: `DMAS_SEG_W] = s[`DMAS_SEG_W-1:0];
            c = s[`DMAS_SEG_W];
        end
        return r;
    endfunction

    function automatic logic [`DMAS_PROD_W-1:0] mul_pre(input dmas_in_type v);
        logic [`DMAS_A_W-1:0] pre;
        logic signed [`DMAS_PROD_W-1:0] sa;
        logic signed [`DMAS_PROD_W-1:0] sb;
        pre = v.ctrl.pre_en ? (v.ctrl.pre_sub ? v.d - v.a : v.d + v.a) : v.a;
        // Both factors are widened first so that the product keeps its full width.
        sa = {{(`DMAS_PROD_W-`DMAS_A_W){pre[`DMAS_A_W-1]}}, pre};
        sb = {{(`DMAS_PROD_W-`DMAS_B_W){v.b[`DMAS_B_W-1]}}, v.b};
        return sa * sb;
    endfunction

    dmas_in_type in_now;
    dmas_in_type in_ff;
    dmas_in_type nxt_in_ff;
    dmas_in_type i_s;
    dmas_mul_type mul_now;
    dmas_mul_type mul_ff;
    dmas_mul_type nxt_mul_ff;
    dmas_mul_type m_s;
    logic [`DMAS_P_W-1:0] x_op;
    logic [`DMAS_P_W-1:0] z_op;
    logic [`DMAS_P_W-1:0] arith;
    logic [`DMAS_P_W-1:0] lgc;
    logic [`DMAS_P_W-1:0] acc_ff;
    logic [`DMAS_P_W-1:0] nxt_acc_ff;
    logic [`DMAS_P_W-1:0] out_ff;
    logic [`DMAS_P_W-1:0] nxt_out_ff;
    logic match_ff;
    logic nxt_match_ff;
    logic wide_ff;
    logic nxt_wide_ff;
    logic [`DMAS_NSEG-1:0] xor_ff;
    logic [`DMAS_NSEG-1:0] xor_now;

    assign in_now = '{ctrl: CTRL, a: MUL_A, d: PRE_D, b: MUL_B, opa: OPA, opc: OPC};

    always_comb begin
        nxt_in_ff = in_now;
        i_s = IN_REG ? in_ff : in_now;
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            in_ff <= '0;
        end else begin
            in_ff <= nxt_in_ff;
        end
    end

    assign mul_now = '{ctrl: i_s.ctrl, prod: mul_pre(i_s), opa: i_s.opa, opc: i_s.opc};

    always_comb begin
        nxt_mul_ff = mul_now;
        m_s = MUL_REG ? mul_ff : mul_now;
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            mul_ff <= '0;
        end else begin
            mul_ff <= nxt_mul_ff;
        end
    end

    assign x_op = m_s.ctrl.bypass ? m_s.opa : {{(`DMAS_P_W-`DMAS_PROD_W){m_s.prod[`DMAS_PROD_W-1]}}, m_s.prod};
    assign z_op = m_s.ctrl.cascade ? CASC_IN : (m_s.ctrl.acc ? acc_ff : m_s.opc);
    assign arith = lane_add(z_op, x_op, m_s.ctrl.sub, m_s.ctrl.lane);

    always_comb begin
        unique case (m_s.ctrl.logic_sel)
            `DMAS_LG_XOR: lgc = x_op ^ z_op;
            `DMAS_LG_XNOR: lgc = ~(x_op ^ z_op);
            `DMAS_LG_AND: lgc = x_op & z_op;
            `DMAS_LG_ANDN: lgc = x_op & ~z_op;
            `DMAS_LG_NAND: lgc = ~(x_op & z_op);
            `DMAS_LG_OR: lgc = x_op | z_op;
            `DMAS_LG_ORN: lgc = x_op | ~z_op;
            `DMAS_LG_NOR: lgc = ~(x_op | z_op);
            `DMAS_LG_NAND_X: lgc = ~x_op & z_op;
            `DMAS_LG_NOR_X: lgc = ~x_op | z_op;
            default: lgc = '0;
        endcase
    end

    // Wide parity over both operands.
    dmas_xor u_xor (
        .data({m_s.opa, m_s.opc}),
        .width(m_s.ctrl.xor_w),
        .parity(xor_now)
    );

    always_comb begin
        nxt_acc_ff = acc_ff;
        unique case (m_s.ctrl.fn)
            FN_ARITH: nxt_acc_ff = arith;
            FN_LOGIC: nxt_acc_ff = lgc;
            FN_COUNT: begin
                if (m_s.ctrl.cnt_en) begin
                    nxt_acc_ff = lane_add(acc_ff, `DMAS_ONE, !m_s.ctrl.cnt_up, LANE_ONE);
                end
            end
            default: nxt_acc_ff = acc_ff;
        endcase
        nxt_match_ff = ((nxt_acc_ff ^ PATTERN) & ~MASK) == '0;
        nxt_wide_ff = nxt_match_ff & CASC_MATCH_IN;
        nxt_out_ff = nxt_acc_ff;
        // convergent rounding clears the tie bit.
        if (m_s.ctrl.rnd_en && nxt_match_ff) begin
            nxt_out_ff[0] = 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            acc_ff <= `DMAS_P_RST;
            out_ff <= `DMAS_P_RST;
            match_ff <= 1'b0;
            wide_ff <= 1'b0;
            xor_ff <= '0;
        end else begin
            acc_ff <= nxt_acc_ff;
            out_ff <= nxt_out_ff;
            match_ff <= nxt_match_ff;
            wide_ff <= nxt_wide_ff;
            xor_ff <= xor_now;
        end
    end

    assign RESULT = out_ff;
    assign CASC_OUT = acc_ff;
    assign PAT_MATCH = match_ff;
    assign PAT_WIDE = wide_ff;
    assign XOR_PAR = xor_ff;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    sequence pure_arith_s;
        m_s.ctrl.fn == FN_ARITH && !m_s.ctrl.acc && !m_s.ctrl.cascade;
    endsequence

    sequence one_lane_add_s;
        pure_arith_s and (m_s.ctrl.lane == LANE_ONE && !m_s.ctrl.sub);
    endsequence

    AST_MULT: assert property (
        !i_s.ctrl.pre_en |=> !MUL_REG || $signed(mul_ff.prod) == $signed($past(i_s.a)) * $signed($past(i_s.b)))
        else $error("product does not match signed operands");

    AST_BYPASS: assert property (
        one_lane_add_s and m_s.ctrl.bypass |=> acc_ff == $past(m_s.opa) + $past(m_s.opc))
        else $error("bypass sum wrong");

    AST_LANE: assert property (
        pure_arith_s and (m_s.ctrl.lane == LANE_QUAD && m_s.ctrl.sub && m_s.ctrl.bypass)
        |=> acc_ff[`DMAS_SEG_W-1:0] == $past(m_s.opc[`DMAS_SEG_W-1:0]) - $past(m_s.opa[`DMAS_SEG_W-1:0])
        && acc_ff[`DMAS_P_W-1 -: `DMAS_SEG_W]
        == $past(m_s.opc[`DMAS_P_W-1 -: `DMAS_SEG_W]) - $past(m_s.opa[`DMAS_P_W-1 -: `DMAS_SEG_W]))
        else $error("lane difference wrong");

    AST_LOGIC: assert property (
        m_s.ctrl.fn == FN_LOGIC && m_s.ctrl.logic_sel == `DMAS_LG_ANDN && !m_s.ctrl.acc && !m_s.ctrl.cascade
        && m_s.ctrl.bypass |=> acc_ff == ($past(m_s.opa) & ~$past(m_s.opc)))
        else $error("logic unit result wrong");

    AST_PREADD: assert property (
        i_s.ctrl.pre_en && !i_s.ctrl.pre_sub |=> !MUL_REG
        || $signed(mul_ff.prod) == $signed(`DMAS_A_W'($past(i_s.a) + $past(i_s.d))) * $signed($past(i_s.b)))
        else $error("pre-added product wrong");

    AST_XOR: assert property (
        m_s.ctrl.xor_w == `DMAS_XW_96
        |=> XOR_PAR[0] == ^{$past(m_s.opa), $past(m_s.opc)} && XOR_PAR[`DMAS_NSEG-1:1] == '0)
        else $error("full-width parity wrong");

    AST_PAT: assert property (
        // The reset edge is left out, as cleared flag and accumulator need not agree.
        !RST |=> PAT_MATCH == (((acc_ff ^ $past(PATTERN)) & ~$past(MASK)) == '0)
        && (!$past(m_s.ctrl.rnd_en) || !PAT_MATCH || RESULT == {acc_ff[`DMAS_P_W-1:1], 1'b0}))
        else $error("pattern flag or rounding wrong");

    AST_WIDE: assert property (
        1'b1 |=> PAT_WIDE == (PAT_MATCH && $past(CASC_MATCH_IN)))
        else $error("chained match wrong");

    AST_COUNT: assert property (
        m_s.ctrl.fn == FN_COUNT && m_s.ctrl.cnt_en ##0 m_s.ctrl.cnt_up
        |=> acc_ff == $past(acc_ff) + `DMAS_ONE)
        else $error("counter did not step up");

    AST_CASC: assert property (
        m_s.ctrl.fn == FN_ARITH && m_s.ctrl.cascade && m_s.ctrl.lane == LANE_ONE && !m_s.ctrl.sub
        && m_s.ctrl.bypass |=> acc_ff == $past(CASC_IN) + $past(m_s.opa) && CASC_OUT == acc_ff)
        else $error("cascade sum wrong");

    AST_CTRL: assert property (
        1'b1 |=> !IN_REG || (in_ff.ctrl == $past(CTRL) && in_ff.opa == $past(OPA)))
        else $error("controls not sampled with operands");

endmodule

// ---- testbench/dmas_nbr.sv ----
`include "dmas_defs.svh"

module dmas_nbr
    import dmas_pkg::*;
(
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic RST,
    // Values the neighbour slice registers.
    input wire logic [`DMAS_P_W-1:0] SUM_IN,
    input wire logic MATCH_IN,
    // Registered cascade toward the slice.
    output logic [`DMAS_P_W-1:0] CASC_SUM,
    output logic CASC_MATCH
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [`DMAS_P_W-1:0] sum_ff;
    logic match_ff;
    logic [`DMAS_P_W-1:0] nxt_sum;
    logic nxt_match;

    always_comb begin
        nxt_sum = SUM_IN;
        nxt_match = MATCH_IN;
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            sum_ff <= '0;
            match_ff <= 1'b0;
        end else begin
            sum_ff <= nxt_sum;
            match_ff <= nxt_match;
        end
    end

    assign CASC_SUM = sum_ff;
    assign CASC_MATCH = match_ff;
endmodule

// ---- testbench/dmas_slice_tb.sv ----
`include "dmas_defs.svh"

module dmas_slice_tb
    import dmas_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [26:0] mul_a = '0;
    logic [26:0] pre_d = '0;
    logic [17:0] mul_b = '0;
    logic [47:0] opa = '0;
    logic [47:0] opc = '0;
    dmas_ctrl_type ctl = '0;
    logic [47:0] pattern = '0;
    logic [47:0] mask = '0;
    logic [47:0] nbr_sum = '0;
    logic nbr_match = 1'b0;
    logic [47:0] casc_in;
    logic casc_match_in;
    logic [47:0] result;
    logic [47:0] casc_out;
    logic pat_match;
    logic pat_wide;
    logic [7:0] xor_par;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;

    dmas_slice u_dmas_slice (
        .CLOCK(clock), .RST(rst), .MUL_A(mul_a), .PRE_D(pre_d), .MUL_B(mul_b),
        .OPA(opa), .OPC(opc), .CTRL(ctl), .PATTERN(pattern), .MASK(mask),
        .CASC_IN(casc_in), .CASC_MATCH_IN(casc_match_in), .RESULT(result),
        .CASC_OUT(casc_out), .PAT_MATCH(pat_match), .PAT_WIDE(pat_wide), .XOR_PAR(xor_par)
    );

    dmas_nbr u_dmas_nbr (
        .CLOCK(clock), .RST(rst), .SUM_IN(nbr_sum), .MATCH_IN(nbr_match),
        .CASC_SUM(casc_in), .CASC_MATCH(casc_match_in)
    );

    always #12.5 clock = ~clock;

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            fails++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic drive(input dmas_ctrl_type c, input logic [26:0] a, input logic [26:0] d,
                         input logic [17:0] b, input logic [47:0] x, input logic [47:0] z);
        @(posedge clock);
        ctl <= c;
        mul_a <= a;
        pre_d <= d;
        mul_b <= b;
        opa <= x;
        opc <= z;
    endtask

    // Inputs are held, so three edges of latency plus one spare.
    task automatic settle();
        repeat (4) @(posedge clock);
        #1;
    endtask

    task automatic t_mul();
        dmas_ctrl_type c = '0;
        drive(c, 27'h7FF_FFFD, '0, 18'h0_0005, '0, 48'h0000_0000_000A);
        drive(c, 27'h400_0000, '0, 18'h2_0000, '0, '0);
        repeat (2) @(posedge clock);
        #1;
        chk("signed product", 48'hFFFF_FFFF_FFFB, result);
        @(posedge clock);
        #1;
        chk("next product", 48'h0800_0000_0000, result);
        chk("cascade out", 48'h0800_0000_0000, casc_out);
    endtask

    task automatic t_pre();
        dmas_ctrl_type c = '0;
        c.pre_en = 1'b1;
        drive(c, 27'h000_0002, 27'h000_0007, 18'h0_0003, '0, '0);
        settle();
        chk("pre add", 48'h0000_0000_001B, result);
        c.pre_sub = 1'b1;
        drive(c, 27'h000_0002, 27'h000_0007, 18'h0_0003, '0, '0);
        settle();
        chk("pre sub", 48'h0000_0000_000F, result);
    endtask

    task automatic t_logic();
        dmas_ctrl_type c = '0;
        logic [47:0] x = 48'h0000_0000_000C;
        logic [47:0] z = 48'h0000_0000_000A;
        logic [47:0] e;
        c.bypass = 1'b1;
        c.fn = FN_LOGIC;
        for (int i = 0; i < 11; i++) begin
            case (i)
                0: e = x ^ z;
                1: e = ~(x ^ z);
                2: e = x & z;
                3: e = x & ~z;
                4: e = ~(x & z);
                5: e = x | z;
                6: e = x | ~z;
                7: e = ~(x | z);
                8: e = ~x & z;
                9: e = ~x | z;
                default: e = '0;
            endcase
            c.logic_sel = 4'(i);
            drive(c, '0, '0, '0, x, z);
            settle();
            chk("logic function", e, result);
        end
    endtask

    task automatic t_lanes();
        dmas_ctrl_type c = '0;
        logic [47:0] e [6] = '{48'h0010_0100_1000, 48'h0010_0000_1000, 48'h0000_0000_0000,
                               48'hFFEF_FEFF_EFFF, 48'hFFEF_FFFF_EFFF, 48'hFFFF_FFFF_FFFF};
        c.bypass = 1'b1;
        for (int i = 0; i < 6; i++) begin
            c.sub = (i >= 3);
            c.lane = dmas_lane_type'(i % 3);
            drive(c, '0, '0, '0, 48'h0010_0100_1001, (i < 3) ? 48'hFFFF_FFFF_FFFF : '0);
            settle();
            chk("lane sum", e[i], result);
        end
    endtask

    task automatic t_xor();
        dmas_ctrl_type c = '0;
        logic [7:0] e [4] = '{8'h81, 8'h09, 8'h03, 8'h00};
        for (int w = 0; w < 4; w++) begin
            c.xor_w = 2'(w);
            drive(c, '0, '0, '0, 48'h8000_0000_0000, 48'h0000_0000_0001);
            settle();
            chk("xor parity", 48'(e[w]), 48'(xor_par));
        end
    endtask

    task automatic t_count();
        dmas_ctrl_type c = '0;
        c.bypass = 1'b1;
        drive(c, '0, '0, '0, '0, 48'h0000_0000_0100);
        settle();
        c.fn = FN_COUNT;
        c.cnt_en = 1'b1;
        c.cnt_up = 1'b1;
        repeat (5) drive(c, '0, '0, '0, '0, '0);
        c.cnt_en = 1'b0;
        drive(c, '0, '0, '0, '0, '0);
        settle();
        chk("count up", 48'h0000_0000_0105, result);
        c.cnt_en = 1'b1;
        c.cnt_up = 1'b0;
        repeat (3) drive(c, '0, '0, '0, '0, '0);
        c.cnt_en = 1'b0;
        drive(c, '0, '0, '0, '0, '0);
        settle();
        chk("count down", 48'h0000_0000_0102, result);
        c.fn = FN_ARITH;
        c.acc = 1'b1;
        c.sub = 1'b1;
        drive(c, '0, '0, '0, 48'h0000_0000_0002, '0);
        c.fn = FN_COUNT;
        c.acc = 1'b0;
        c.sub = 1'b0;
        drive(c, '0, '0, '0, '0, '0);
        settle();
        chk("accumulate sub", 48'h0000_0000_0100, result);
        c.fn = dmas_fn_type'(2'h2);
        drive(c, '0, '0, '0, 48'h0000_0000_0005, 48'h0000_0000_0007);
        settle();
        chk("hold code", 48'h0000_0000_0100, result);
    endtask

    task automatic t_pattern();
        dmas_ctrl_type c = '0;
        c.bypass = 1'b1;
        c.cascade = 1'b1;
        c.rnd_en = 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            pattern <= (i == 0) ? 48'h0000_0000_0005 : 48'h0000_0000_0007;
            mask <= (i == 2) ? 48'h0000_0000_0002 : '0;
            nbr_sum <= 48'h0000_0000_0004;
            nbr_match <= (i != 2);
            drive(c, '0, '0, '0, 48'h0000_0000_0001, '0);
            settle();
            chk("match", 48'(i != 1), 48'(pat_match));
            chk("wide match", 48'(i == 0), 48'(pat_wide));
            chk("rounded", (i == 1) ? 48'h0000_0000_0005 : 48'h0000_0000_0004, result);
            chk("cascade sum", 48'h0000_0000_0005, casc_out);
        end
    endtask

    initial begin
        repeat (10) @(posedge clock);
        #1;
        chk("reset result", '0, result);
        @(posedge clock);
        rst <= 1'b0;
        t_mul();
        t_pre();
        t_logic();
        t_lanes();
        t_xor();
        t_count();
        t_pattern();
        test_done();
    end
endmodule
